// >>> card_host_regs.vh
// Timing and field constants for the flash card host controller
`ifndef CARD_HOST_REGS_VH
`define CARD_HOST_REGS_VH
`define CLK_PERIOD_NS        5
`define RESET_HOLD_NS        500
`define RESET_HOLD_CYC       ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOVER_NS     20000
`define RESET_RECOVER_CYC    (`RESET_RECOVER_NS / `CLK_PERIOD_NS)
`define STROBE_CYC           30
`define SETUP_CYC            8
`define ATTR_PROTECT_LIMIT   10'h080
`define ATTR_SIZE            10'h200
`define ADDR_WIDTH           25
`define SEGMENT_BYTES        32'h00200000
`define SECTOR_BYTES         32'h00010000
`define SIZE_BYTE_LOW        2'h0
`define SIZE_BYTE_HIGH       2'h1
`define SIZE_WORD            2'h2
`endif

// >>> pulse_timer.v
// Down counter that times one bus phase
`timescale 1ns/10ps
module pulse_timer #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             load,
    input  wire [WIDTH-1:0] count,
    output reg              done
);
    reg [WIDTH-1:0] remain;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= {WIDTH{1'b0}};
            done   <= 1'b0;
        end else if (load) begin
            remain <= count;
            done   <= 1'b0;
        end else if (remain != {WIDTH{1'b0}}) begin
            remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
            done   <= (remain == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done <= 1'b0;
        end
    end
endmodule // pulse_timer

// >>> card_host.v
// Host socket controller that drives a flash memory card over its bus pins
//
// Contract
// - Host drives all address lines every cycle
// - Hold reset 500 ns, wait 20 us
// - Never reset during program or erase
// - Attribute data valid only on low lane
// - Word access asserts both selects
// - Attribute read holds select and gate
// - Attribute write holds select, strobe, gate off
`timescale 1ns/10ps
`include "card_host_regs.vh"
module card_host #(
    parameter RESET_HOLD    = `RESET_HOLD_CYC,
    parameter RESET_RECOVER = `RESET_RECOVER_CYC,
    parameter STROBE        = `STROBE_CYC,
    parameter SETUP         = `SETUP_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire        req_attr,
    input  wire [1:0]  req_size,
    input  wire [24:0] req_addr,
    input  wire [15:0] req_wdata,
    input  wire        reset_req,
    output reg         req_ready,
    output reg         rsp_valid,
    output reg         rsp_error,
    output reg  [15:0] rsp_rdata,
    output reg         card_ready,
    output reg  [24:0] card_addr,
    output reg         low_lane_card_select_n,
    output reg         high_lane_card_select_n,
    output reg         output_gate_n,
    output reg         write_strobe_n,
    output reg         attr_select_n,
    output reg         card_reset,
    output reg  [7:0]  low_data_lane_out,
    output reg         low_data_lane_oe_n,
    output reg  [7:0]  high_data_lane_out,
    output reg         high_data_lane_oe_n,
    input  wire [7:0]  low_data_lane_in,
    input  wire [7:0]  high_data_lane_in,
    input  wire        ready_busy_flag,
    input  wire        write_lock
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [6:0] ST_IDLE    = 7'h01;
    localparam [6:0] ST_SETUP   = 7'h02;
    localparam [6:0] ST_STROBE  = 7'h04;
    localparam [6:0] ST_HOLD    = 7'h08;
    localparam [6:0] ST_RST_ON  = 7'h10;
    localparam [6:0] ST_RST_OFF = 7'h20;
    localparam [6:0] ST_DONE    = 7'h40;

    reg  [6:0]  state;
    reg  [6:0]  next_state;
    reg         timer_load;
    reg  [15:0] timer_count;
    wire        timer_done;
    reg         cur_write;
    reg         cur_attr;
    reg  [1:0]  cur_size;
    reg  [15:0] wdata;
    reg         pending_reset;

    pulse_timer #(.WIDTH(16)) u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (timer_load),
        .count (timer_count),
        .done  (timer_done)
    );

    // ------------------------------------------------------------
    // Request checks
    // ------------------------------------------------------------
    wire attr_locked = req_attr && req_write && (req_addr[9:0] < `ATTR_PROTECT_LIMIT);
    wire reject      = req_write && (write_lock || attr_locked);
    wire bad_size    = (req_size == 2'h3);

    always @* begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_count = 16'h0000;
        case (state)
            ST_IDLE: begin
                if (pending_reset && ready_busy_flag) begin
                    next_state  = ST_RST_ON;
                    timer_load  = 1'b1;
                    timer_count = RESET_HOLD[15:0];
                end else if (req_valid && !reject && !bad_size && ready_busy_flag && !pending_reset) begin
                    next_state  = ST_SETUP;
                    timer_load  = 1'b1;
                    timer_count = SETUP[15:0];
                end
            end
            ST_SETUP: begin
                if (timer_done) begin
                    next_state  = ST_STROBE;
                    timer_load  = 1'b1;
                    timer_count = STROBE[15:0];
                end
            end
            ST_STROBE: begin
                if (timer_done) begin
                    next_state  = ST_HOLD;
                    timer_load  = 1'b1;
                    timer_count = SETUP[15:0];
                end
            end
            ST_HOLD: begin
                if (timer_done) begin
                    next_state = ST_DONE;
                end
            end
            ST_RST_ON: begin
                if (timer_done) begin
                    next_state  = ST_RST_OFF;
                    timer_load  = 1'b1;
                    timer_count = RESET_RECOVER[15:0];
                end
            end
            ST_RST_OFF: begin
                if (timer_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Pin and response registers
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                   <= ST_IDLE;
            cur_write               <= 1'b0;
            cur_attr                <= 1'b0;
            cur_size                <= 2'h0;
            wdata                   <= 16'h0000;
            pending_reset           <= 1'b0;
            req_ready               <= 1'b0;
            rsp_valid               <= 1'b0;
            rsp_error               <= 1'b0;
            rsp_rdata               <= 16'h0000;
            card_ready              <= 1'b0;
            card_addr               <= 25'h0000000;
            low_lane_card_select_n  <= 1'b1;
            high_lane_card_select_n <= 1'b1;
            output_gate_n           <= 1'b1;
            write_strobe_n          <= 1'b1;
            attr_select_n           <= 1'b1;
            card_reset              <= 1'b0;
            low_data_lane_out       <= 8'h00;
            low_data_lane_oe_n      <= 1'b1;
            high_data_lane_out      <= 8'h00;
            high_data_lane_oe_n     <= 1'b1;
        end else begin
            state      <= next_state;
            rsp_valid  <= 1'b0;
            rsp_error  <= 1'b0;
            card_ready <= ready_busy_flag && (state != ST_RST_ON) && (state != ST_RST_OFF);
            req_ready  <= (next_state == ST_IDLE) && ready_busy_flag && !pending_reset;
            if (reset_req) begin
                pending_reset <= 1'b1;
            end else if (state == ST_RST_ON) begin
                pending_reset <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (next_state == ST_SETUP) begin
                        cur_write     <= req_write;
                        cur_attr      <= req_attr;
                        cur_size      <= req_size;
                        card_addr     <= req_addr;
                        attr_select_n <= ~req_attr;
                        if (req_size == `SIZE_WORD) begin
                            low_lane_card_select_n  <= 1'b0;
                            high_lane_card_select_n <= 1'b0;
                        end else if (req_size == `SIZE_BYTE_HIGH) begin
                            low_lane_card_select_n  <= 1'b1;
                            high_lane_card_select_n <= 1'b0;
                        end else begin
                            low_lane_card_select_n  <= 1'b0;
                            high_lane_card_select_n <= 1'b1;
                        end
                        if (req_size == `SIZE_BYTE_LOW && req_addr[0]) begin
                            wdata <= {8'h00, req_wdata[15:8]};
                        end else begin
                            wdata <= req_wdata;
                        end
                    end else if (req_valid && req_ready && (reject || bad_size)) begin
                        rsp_valid <= 1'b1;
                        rsp_error <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    if (timer_done) begin
                        if (cur_write) begin
                            write_strobe_n <= 1'b0;
                            output_gate_n  <= 1'b1;
                            low_data_lane_oe_n  <= ~(cur_size != `SIZE_BYTE_HIGH);
                            high_data_lane_oe_n <= ~(cur_size != `SIZE_BYTE_LOW) | cur_attr;
                            low_data_lane_out   <= (cur_size == `SIZE_BYTE_HIGH) ? 8'h00 : wdata[7:0];
                            high_data_lane_out  <= wdata[15:8];
                        end else begin
                            output_gate_n <= 1'b0;
                        end
                    end
                end
                ST_STROBE: begin
                    if (timer_done) begin
                        if (!cur_write) begin
                            if (cur_attr) begin
                                rsp_rdata <= {8'h00, low_data_lane_in};
                            end else if (cur_size == `SIZE_BYTE_HIGH) begin
                                rsp_rdata <= {high_data_lane_in, 8'h00};
                            end else if (cur_size == `SIZE_BYTE_LOW) begin
                                rsp_rdata <= {8'h00, low_data_lane_in};
                            end else begin
                                rsp_rdata <= {high_data_lane_in, low_data_lane_in};
                            end
                        end
                        write_strobe_n <= 1'b1;
                        output_gate_n  <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (timer_done) begin
                        low_data_lane_oe_n      <= 1'b1;
                        high_data_lane_oe_n     <= 1'b1;
                        low_lane_card_select_n  <= 1'b1;
                        high_lane_card_select_n <= 1'b1;
                        attr_select_n           <= 1'b1;
                    end
                end
                ST_DONE: begin
                    rsp_valid <= 1'b1;
                end
                default: begin
                    if (next_state == ST_RST_ON || state == ST_RST_ON) begin
                        low_data_lane_oe_n  <= 1'b1;
                        high_data_lane_oe_n <= 1'b1;
                    end
                end
            endcase
            card_reset <= (next_state == ST_RST_ON);
        end
    end
endmodule // card_host

// >>> card_host_chk.sv
// Pin protocol checker for the card host controller
`timescale 1ns/10ps
module card_host_chk #(
    parameter RESET_HOLD = 100
) (
    input wire        clk,
    input wire        rst_n,
    input wire [24:0] card_addr,
    input wire        low_lane_card_select_n,
    input wire        high_lane_card_select_n,
    input wire        output_gate_n,
    input wire        write_strobe_n,
    input wire        attr_select_n,
    input wire        card_reset,
    input wire [7:0]  low_data_lane_out,
    input wire        low_data_lane_oe_n,
    input wire        high_data_lane_oe_n,
    input wire        ready_busy_flag,
    input wire        write_lock
);
    // ----
    // Reset pulse length
    // ----
    reg [15:0] rcnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) rcnt <= 16'h0000;
        else rcnt <= card_reset ? rcnt + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_strobe;
        !write_strobe_n;
    endsequence
    // Strobe already low one cycle: lanes were launched with its fall
    sequence s_strobe_on;
        !write_strobe_n && !$past(write_strobe_n);
    endsequence
    sequence s_reset_end;
        $fell(card_reset);
    endsequence
    a_strobe_no_gate:
        assert property (s_strobe |-> output_gate_n) else $error("gate low in write");
    a_addr_held:
        assert property (s_strobe_on |-> $stable(card_addr) && $stable(low_data_lane_out)) else $error("addr moved");
    a_gate_no_drive:
        assert property (!output_gate_n |-> low_data_lane_oe_n && high_data_lane_oe_n) else $error("lane clash");
    a_select_in_use:
        assert property (!(write_strobe_n && output_gate_n) |->
            !(low_lane_card_select_n && high_lane_card_select_n)) else $error("no select");
    a_word_both_lanes:
        assert property (s_strobe ##0 (!low_lane_card_select_n && !high_lane_card_select_n && attr_select_n)
            |-> !low_data_lane_oe_n && !high_data_lane_oe_n) else $error("word lane idle");
    a_reset_hold:
        assert property (s_reset_end |-> rcnt >= RESET_HOLD) else $error("reset short");
    a_reset_quiet:
        assert property (card_reset |-> low_lane_card_select_n && high_lane_card_select_n
            && low_data_lane_oe_n && high_data_lane_oe_n) else $error("bus used in reset");
    a_reset_when_ready:
        assert property ($rose(card_reset) |-> $past(ready_busy_flag)) else $error("reset while busy");
    a_lock_no_write:
        assert property ($fell(write_strobe_n) |-> !write_lock) else $error("write while locked");
    a_attr_held:
        assert property (!output_gate_n || !write_strobe_n |-> $stable(attr_select_n)) else $error("attr moved");
endmodule // card_host_chk
bind card_host card_host_chk #(.RESET_HOLD(RESET_HOLD)) chk_u (.clk, .rst_n, .card_addr,
    .low_lane_card_select_n, .high_lane_card_select_n, .output_gate_n, .write_strobe_n, .attr_select_n,
    .card_reset, .low_data_lane_out, .low_data_lane_oe_n, .high_data_lane_oe_n, .ready_busy_flag, .write_lock);

// >>> card_model.sv
// Behavioural flash card seen by the host controller
`timescale 1ns/10ps
module card_model #(
    parameter RECOVER_NS = 20000
) (
    input  wire [24:0] addr,
    input  wire        lsel_n,
    input  wire        hsel_n,
    input  wire        gate_n,
    input  wire        wr_n,
    input  wire        attr_n,
    input  wire        rst,
    input  wire        lock,
    input  wire [7:0]  lo_out,
    input  wire        lo_oe_n,
    input  wire [7:0]  hi_out,
    input  wire        hi_oe_n,
    output wire [7:0]  lo,
    output wire [7:0]  hi,
    output reg         ready
);
    reg  [15:0] mem [0:63];
    reg  [7:0]  amem [0:511];
    reg  [24:0] wa;
    reg  [7:0]  l_last;
    reg  [7:0]  h_last;
    integer     i;
    wire [15:0] w    = mem[addr[6:1]];
    wire        rd   = !rst && !gate_n;
    wire        l_en = rd && !lsel_n;
    wire        h_en = rd && !hsel_n && attr_n;
    wire [7:0]  l_val = !attr_n ? amem[addr[8:0]] : (hsel_n && addr[0]) ? w[15:8] : w[7:0];
    // Undriven lanes show the inverse of their last value
    assign lo = !lo_oe_n ? lo_out : l_en ? l_val : ~l_last;
    assign hi = !hi_oe_n ? hi_out : h_en ? w[15:8] : ~h_last;
    initial begin
        for (i = 0; i < 512; i = i + 1) amem[i] = 8'hff;
        for (i = 0; i < 64; i = i + 1) mem[i] = 16'hffff;
        l_last = 8'h00;
        h_last = 8'h00;
        wa = 25'h0000000;
        ready = 1'b1;
    end
    always @(posedge gate_n) begin
        l_last = l_val;
        h_last = w[15:8];
    end
    always @(negedge wr_n) wa = addr;
    always @(posedge wr_n) begin
        if (!lock && !rst) begin
            if (!attr_n) begin
                if (wa[8:0] >= 9'h080) amem[wa[8:0]] = lo;
            end else if (!lsel_n && !hsel_n) mem[wa[6:1]] = mem[wa[6:1]] & {hi, lo};
            else if (!lsel_n && wa[0]) mem[wa[6:1]][15:8] = mem[wa[6:1]][15:8] & lo;
            else if (!lsel_n) mem[wa[6:1]][7:0] = mem[wa[6:1]][7:0] & lo;
            else if (!hsel_n) mem[wa[6:1]][15:8] = mem[wa[6:1]][15:8] & hi;
            ready = 1'b0;
            #102;
            ready = 1'b1;
        end
    end
    always @(posedge rst) ready = 1'b0;
    always @(negedge rst) begin
        #(RECOVER_NS + 2);
        ready = 1'b1;
    end
endmodule // card_model

// >>> card_host_tb.sv
// Self-checking bench for the flash card host controller
`timescale 1ns/10ps
module card_host_tb;
    reg         clk, rst_n, req_valid, req_write, req_attr, reset_req, write_lock;
    reg  [1:0]  req_size;
    reg  [24:0] req_addr;
    reg  [15:0] req_wdata;
    wire        req_ready, rsp_valid, rsp_error, card_ready, low_lane_card_select_n, high_lane_card_select_n;
    wire        output_gate_n, write_strobe_n, attr_select_n, card_reset, low_data_lane_oe_n, high_data_lane_oe_n;
    wire        ready_busy_flag;
    wire [15:0] rsp_rdata;
    wire [24:0] card_addr;
    wire [7:0]  low_data_lane_out, high_data_lane_out, low_data_lane_in, high_data_lane_in;
    integer     n_errors, cmp_count, k;
    card_host #(.RESET_RECOVER(4), .STROBE(4), .SETUP(2)) dut_u (.clk, .rst_n, .req_valid, .req_write,
        .req_attr, .req_size, .req_addr, .req_wdata, .reset_req, .req_ready, .rsp_valid, .rsp_error, .rsp_rdata,
        .card_ready, .card_addr, .low_lane_card_select_n, .high_lane_card_select_n, .output_gate_n,
        .write_strobe_n, .attr_select_n, .card_reset, .low_data_lane_out, .low_data_lane_oe_n,
        .high_data_lane_out, .high_data_lane_oe_n, .low_data_lane_in, .high_data_lane_in, .ready_busy_flag,
        .write_lock);
    card_model card_u (.addr(card_addr), .lsel_n(low_lane_card_select_n), .hsel_n(high_lane_card_select_n),
        .gate_n(output_gate_n), .wr_n(write_strobe_n), .attr_n(attr_select_n), .rst(card_reset), .lock(write_lock),
        .lo_out(low_data_lane_out), .lo_oe_n(low_data_lane_oe_n), .hi_out(high_data_lane_out),
        .hi_oe_n(high_data_lane_oe_n), .lo(low_data_lane_in), .hi(high_data_lane_in), .ready(ready_busy_flag));
    task summarize;
        begin
            if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [47:0] nm, input [15:0] exp, input [15:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Bounded wait: 0 ready, 1 response, 2 card reset, 3 card ready
    task await(input [1:0] s);
        begin
            k = 0;
            while ((s == 0 ? req_ready : s == 1 ? rsp_valid : s == 2 ? card_reset : card_ready) !== 1'b1) begin
                @(negedge clk);
                k = k + 1;
                if (k > 6000) begin
                    chk("wait", 16'h0001, 16'h0000);
                    summarize;
                end
            end
        end
    endtask
    task xfer(input w, input a, input [1:0] sz, input [24:0] ad, input [15:0] wd, input e, input [15:0] m,
              input [15:0] x);
        begin
            @(negedge clk);
            await(0);
            req_valid = 1'b1;
            req_write = w;
            req_attr = a;
            req_size = sz;
            req_addr = ad;
            req_wdata = wd;
            @(negedge clk);
            req_valid = 1'b0;
            await(1);
            chk("error", {15'h0000, e}, {15'h0000, rsp_error});
            if (!w && !e) chk("rdata", x, rsp_rdata & m);
        end
    endtask
    task t_word;
        begin
            xfer(1, 0, 2'h2, 25'h4, 16'h1234, 0, 16'h0000, 16'h0000);
            chk("busy", 16'h0000, {15'h0000, card_ready});
            xfer(0, 0, 2'h2, 25'h4, 16'h0000, 0, 16'hffff, 16'h1234);
            xfer(1, 0, 2'h2, 25'h4, 16'h00ff, 0, 16'h0000, 16'h0000);
            xfer(0, 0, 2'h2, 25'h4, 16'h0000, 0, 16'hffff, 16'h0034);
        end
    endtask
    task t_byte;
        begin
            xfer(1, 0, 2'h0, 25'h6, 16'h00ab, 0, 16'h0000, 16'h0000);
            xfer(1, 0, 2'h0, 25'h7, 16'hcd00, 0, 16'h0000, 16'h0000);
            xfer(0, 0, 2'h2, 25'h6, 16'h0000, 0, 16'hffff, 16'hcdab);
            xfer(0, 0, 2'h0, 25'h7, 16'h0000, 0, 16'h00ff, 16'h00cd);
            xfer(1, 0, 2'h1, 25'h9, 16'hef00, 0, 16'h0000, 16'h0000);
            xfer(0, 0, 2'h1, 25'h9, 16'h0000, 0, 16'hff00, 16'hef00);
            xfer(0, 0, 2'h2, 25'h8, 16'h0000, 0, 16'hffff, 16'hefff);
        end
    endtask
    task t_attr;
        begin
            xfer(1, 1, 2'h0, 25'h100, 16'h005a, 0, 16'h0000, 16'h0000);
            xfer(0, 1, 2'h0, 25'h100, 16'h0000, 0, 16'h00ff, 16'h005a);
            xfer(1, 1, 2'h0, 25'h07f, 16'h0011, 1, 16'h0000, 16'h0000);
            xfer(0, 1, 2'h0, 25'h07f, 16'h0000, 0, 16'h00ff, 16'h00ff);
            xfer(1, 1, 2'h0, 25'h080, 16'h0000, 0, 16'h0000, 16'h0000);
            xfer(0, 1, 2'h0, 25'h080, 16'h0000, 0, 16'h00ff, 16'h0000);
        end
    endtask
    task t_lock;
        begin
            write_lock = 1'b1;
            xfer(1, 0, 2'h2, 25'ha, 16'h0000, 1, 16'h0000, 16'h0000);
            write_lock = 1'b0;
            xfer(0, 0, 2'h2, 25'ha, 16'h0000, 0, 16'hffff, 16'hffff);
            xfer(0, 0, 2'h3, 25'ha, 16'h0000, 1, 16'h0000, 16'h0000);
        end
    endtask
    task t_reset;
        begin
            xfer(1, 0, 2'h2, 25'h4, 16'h00ff, 0, 16'h0000, 16'h0000);
            reset_req = 1'b1;
            await(2);
            chk("defer", 16'h0001, {15'h0000, k > 10});
            reset_req = 1'b0;
            k = 0;
            while (card_reset === 1'b1 && k < 300) begin
                k = k + 1;
                @(negedge clk);
            end
            chk("hold", 16'd101, k[15:0]);
            await(3);
            xfer(0, 0, 2'h2, 25'h4, 16'h0000, 0, 16'hffff, 16'h0034);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        n_errors = 0;
        cmp_count = 0;
        {rst_n, req_valid, req_write, req_attr, reset_req, write_lock} = 6'h00;
        req_size = 2'h0;
        req_addr = 25'h0;
        req_wdata = 16'h0000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_word;
        t_byte;
        t_attr;
        t_lock;
        t_reset;
        summarize;
    end
endmodule // card_host_tb
